// ===== acl_defs.svh
// What this block does
// - Layer select 00 disables a rule; it never matches.
// - Layer select 01 is Layer 2, 10 is Layer 3, 11 is Layer 4.
// - Layer 2 option 01 tests EtherType, 10 the MAC, 11 both.
// - Layer 2 option 00 is count mode: tests MAC and EtherType, drives a counter.
// - Source select 0 picks the destination field, 1 the source field.
// - Match sense 1 makes equality true; 0 makes inequality true.
// - Count value is the 11 concatenated action priority, remark and map bits.
// - Action time unit 0 ticks each microsecond, 1 each millisecond.
// - Watchdog algorithm reloads on a packet, counts down, interrupts on expiry.
// - Event algorithm counts packets, interrupts at the terminal count, then restarts.
// - Layer 3 option 01 is masked single address, 10 both addresses; rest reserved.
// - Masked compare checks only address bits whose ignore bit is 0.
// - Layer 3 option 10 compares source to address and destination to mask field.
// - Layer 4 option 00 protocol, 01 TCP ports, 10 UDP ports, 11 sequence.
// - Protocol compare checks the frame protocol byte against the rule byte.
// - Ports use two 16-bit bounds; sequence uses both as one 32-bit word.
// - Port mode 00 off, 01 equals a bound, 10 inside range, 11 outside.
// - TCP flag compare is added to Layer 4 rules only while its enable bit is 1.
// - Flag bits are compared only where the flag ignore mask bit is 0.
// - Remaining rule fields are decoded by layer select and compare option together.
// - Sixteen rules; a selection group ANDs its chosen rules into one match.
// - Count-mode interrupts are per port with status and mask; filters never interrupt.
`ifndef ACL_DEFS_SVH
`define ACL_DEFS_SVH
`define ACL_NUM_RULES 16
`define ACL_NUM_PORTS 7
`define ACL_COUNT_W 11
`define ACL_MD_OFF 2'h0
`define ACL_MD_L2 2'h1
`define ACL_MD_L3 2'h2
`define ACL_MD_L4 2'h3
`define ACL_L2_COUNT 2'h0
`define ACL_L2_TYPE 2'h1
`define ACL_L2_MAC 2'h2
`define ACL_L2_BOTH 2'h3
`define ACL_L3_RSV0 2'h0
`define ACL_L3_MASKED 2'h1
`define ACL_L3_PAIR 2'h2
`define ACL_L3_RSV3 2'h3
`define ACL_L4_PROTO 2'h0
`define ACL_L4_TCP 2'h1
`define ACL_L4_UDP 2'h2
`define ACL_L4_SEQ 2'h3
`define ACL_PC_OFF 2'h0
`define ACL_PC_EITHER 2'h1
`define ACL_PC_IN 2'h2
`define ACL_PC_OUT 2'h3
`define ACL_CA_WATCHDOG 1'h0
`define ACL_CA_EVENT 1'h1
`define ACL_TU_MS 1'h1
`define ACL_CLK_PERIOD_NS 40
`define ACL_TICK_US_NS 1000
`define ACL_US_CYCLES (`ACL_TICK_US_NS / `ACL_CLK_PERIOD_NS)
`define ACL_TICK_MS_US 1000
`endif

// ===== acl_pkg.sv
package acl_pkg;
  typedef struct packed {
    logic [1:0] match_layer_select;
    logic [1:0] compare_option_select;
    logic src_sel;
    logic match_sense;
    logic [47:0] key_addr;
    logic [31:0] ipv4_compare_ignore_bits;
    logic [15:0] key_type;
    logic [15:0] port_hi;
    logic [15:0] port_lo;
    logic [1:0] port_compare_mode;
    logic [7:0] ipv4_upper_layer_id;
    logic tcp_control_bits_match_on;
    logic [7:0] tcp_control_bits_ignore_mask;
    logic [7:0] tcp_flag_value;
  } rule_cfg_s;

  typedef struct packed {
    logic [1:0] prio_mode;
    logic [2:0] prio_value;
    logic remark_on;
    logic [2:0] remark_value;
    logic [1:0] map_mode;
    logic count_time_unit;
    logic counter_algorithm;
  } action_cfg_s;

  typedef struct packed {
    logic [47:0] dst_mac;
    logic [47:0] src_mac;
    logic [15:0] ethertype;
    logic is_ipv4;
    logic [31:0] src_ip;
    logic [31:0] dst_ip;
    logic [7:0] ipv4_upper_layer_id;
    logic is_tcp;
    logic is_udp;
    logic [15:0] src_port;
    logic [15:0] dst_port;
    logic [31:0] tcp_seq;
    logic [7:0] tcp_flags;
  } frame_s;

  typedef enum logic {CNT_IDLE, CNT_ARMED} cnt_state_e;
endpackage

// ===== acl_rule_compare.sv
`timescale 1ns/1ns
`include "acl_defs.svh"
module acl_rule_compare (
  // Rule and frame
  input acl_pkg::rule_cfg_s i_cfg,
  input acl_pkg::frame_s i_frame,
  // Result
  output logic o_hit
);
  import acl_pkg::*;
  logic [47:0] mac;
  logic [31:0] ip;
  logic [15:0] port;
  logic port_ok;
  logic flag_ok;
  logic cmp;
  logic kind;

  always_comb begin
    mac = i_cfg.src_sel ? i_frame.src_mac : i_frame.dst_mac;
    ip = i_cfg.src_sel ? i_frame.src_ip : i_frame.dst_ip;
    port = i_cfg.src_sel ? i_frame.src_port : i_frame.dst_port;
    unique case (i_cfg.port_compare_mode)
      `ACL_PC_OFF: port_ok = 1'b1;
      `ACL_PC_EITHER: port_ok = (port == i_cfg.port_hi) || (port == i_cfg.port_lo);
      `ACL_PC_IN: port_ok = (port >= i_cfg.port_lo) && (port <= i_cfg.port_hi);
      `ACL_PC_OUT: port_ok = (port < i_cfg.port_lo) || (port > i_cfg.port_hi);
    endcase
    // Flag test needs a TCP header to look at
    flag_ok = !i_cfg.tcp_control_bits_match_on || (i_frame.is_tcp &&
      (((i_frame.tcp_flags ^ i_cfg.tcp_flag_value) &
        ~i_cfg.tcp_control_bits_ignore_mask) == 8'h00));
    cmp = 1'b0;
    kind = 1'b0;
    unique case (i_cfg.match_layer_select)
      `ACL_MD_OFF: kind = 1'b0;
      `ACL_MD_L2: begin
        kind = 1'b1;
        unique case (i_cfg.compare_option_select)
          `ACL_L2_TYPE: cmp = i_frame.ethertype == i_cfg.key_type;
          `ACL_L2_MAC: cmp = mac == i_cfg.key_addr;
          `ACL_L2_COUNT, `ACL_L2_BOTH: begin
            cmp = (mac == i_cfg.key_addr) && (i_frame.ethertype == i_cfg.key_type);
          end
        endcase
      end
      `ACL_MD_L3: begin
        unique case (i_cfg.compare_option_select)
          `ACL_L3_MASKED: begin
            kind = i_frame.is_ipv4;
            cmp = ((ip ^ i_cfg.key_addr[31:0]) & ~i_cfg.ipv4_compare_ignore_bits) ==
              32'h00000000;
          end
          `ACL_L3_PAIR: begin
            kind = i_frame.is_ipv4;
            cmp = (i_frame.src_ip == i_cfg.key_addr[31:0]) &&
              (i_frame.dst_ip == i_cfg.ipv4_compare_ignore_bits);
          end
          `ACL_L3_RSV0, `ACL_L3_RSV3: kind = 1'b0;
        endcase
      end
      `ACL_MD_L4: begin
        unique case (i_cfg.compare_option_select)
          `ACL_L4_PROTO: begin
            kind = i_frame.is_ipv4;
            cmp = i_frame.ipv4_upper_layer_id == i_cfg.ipv4_upper_layer_id;
          end
          `ACL_L4_TCP: begin
            kind = i_frame.is_tcp;
            cmp = port_ok;
          end
          `ACL_L4_UDP: begin
            kind = i_frame.is_udp;
            cmp = port_ok;
          end
          `ACL_L4_SEQ: begin
            kind = i_frame.is_tcp;
            cmp = i_frame.tcp_seq == {i_cfg.port_hi, i_cfg.port_lo};
          end
        endcase
        cmp = cmp && flag_ok;
      end
    endcase
    // Sense applies to the whole result; absent header never matches
    o_hit = kind && (cmp == i_cfg.match_sense);
  end
endmodule // acl_rule_compare

// ===== acl_count_unit.sv
`timescale 1ns/1ns
`include "acl_defs.svh"
module acl_count_unit (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_enable,
  input wire logic i_hit,
  input wire logic i_tick_us,
  input wire logic i_tick_ms,
  input acl_pkg::action_cfg_s i_action,
  // Event
  output logic o_expire
);
  import acl_pkg::*;
  localparam int CW = `ACL_COUNT_W;
  cnt_state_e state_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_value;
  logic [CW-1:0] count_inc;
  logic tick;

  assign count_value = {i_action.prio_mode, i_action.prio_value, i_action.remark_on,
    i_action.remark_value, i_action.map_mode};
  assign count_inc = count_reg + 1'b1;
  assign tick = (i_action.count_time_unit == `ACL_TU_MS) ? i_tick_ms : i_tick_us;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= CNT_IDLE;
      count_reg <= '0;
      o_expire <= 1'b0;
    end else begin
      o_expire <= 1'b0;
      if (!i_enable) begin
        state_reg <= CNT_IDLE;
        count_reg <= '0;
      end else if (i_action.counter_algorithm == `ACL_CA_EVENT) begin
        state_reg <= CNT_IDLE;
        if (i_hit) begin
          if (count_inc == count_value) begin
            count_reg <= '0;
            o_expire <= 1'b1;
          end else begin
            count_reg <= count_inc;
          end
        end
      end else if (i_hit) begin
        count_reg <= count_value;
        state_reg <= CNT_ARMED;
      end else if (state_reg == CNT_ARMED && tick) begin
        // One interrupt per silence; rearmed only by the next packet
        if (count_reg <= 11'h001) begin
          count_reg <= '0;
          state_reg <= CNT_IDLE;
          o_expire <= 1'b1;
        end else begin
          count_reg <= count_reg - 1'b1;
        end
      end
    end
  end

  chk_event_wrap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_enable && i_action.counter_algorithm == `ACL_CA_EVENT && i_hit &&
      count_inc == count_value |=> o_expire && count_reg == '0)
    else $error("event counter missed terminal count");

  chk_watch_expire: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_enable && i_action.counter_algorithm == `ACL_CA_WATCHDOG && !i_hit &&
      state_reg == CNT_ARMED && tick && count_reg <= 11'h001
      |=> o_expire && state_reg == CNT_IDLE)
    else $error("watchdog did not expire");

  chk_watch_reload: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_enable && i_action.counter_algorithm == `ACL_CA_WATCHDOG && i_hit
      |=> !o_expire && count_reg == $past(count_value) && state_reg == CNT_ARMED)
    else $error("watchdog not reloaded by packet");
endmodule // acl_count_unit

// ===== acl_match_engine.sv
`timescale 1ns/1ns
`include "acl_defs.svh"
module acl_match_engine #(
  parameter int NUM_RULES = `ACL_NUM_RULES,
  parameter int NUM_PORTS = `ACL_NUM_PORTS,
  parameter int PORT_W = $clog2(NUM_PORTS),
  parameter int US_CYCLES = `ACL_US_CYCLES,
  parameter int MS_US = `ACL_TICK_MS_US
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Parsed frame from ingress
  input wire logic i_frame_valid,
  input acl_pkg::frame_s i_frame,
  input wire logic [PORT_W-1:0] i_frame_port,
  // Table contents
  input acl_pkg::rule_cfg_s i_rule_cfg [NUM_RULES],
  input acl_pkg::action_cfg_s i_action_cfg [NUM_RULES],
  input wire logic [NUM_RULES-1:0] i_match_selection_group [NUM_RULES],
  // Interrupt control
  input wire logic [NUM_PORTS-1:0] i_irq_mask,
  input wire logic [NUM_PORTS-1:0] i_irq_clear,
  // Results
  output logic o_match_valid,
  output logic [NUM_RULES-1:0] o_match_vec,
  output logic [NUM_RULES-1:0] o_set_match,
  // Interrupts
  output logic [NUM_PORTS-1:0] o_irq_status,
  output logic [NUM_PORTS-1:0] o_port_irq,
  output logic o_irq
);
  import acl_pkg::*;

  localparam int US_W = $clog2(US_CYCLES + 1);
  localparam int MS_W = $clog2(MS_US + 1);
  localparam int US_PERIOD = US_CYCLES;

  logic [1:0] rst_sync_reg;
  logic rst_n;

  logic [US_W-1:0] us_cnt_reg;
  logic [MS_W-1:0] ms_cnt_reg;
  logic tick_us_reg;
  logic tick_ms_reg;

  logic [NUM_RULES-1:0] hit;
  logic [NUM_RULES-1:0] count_rule;
  logic [NUM_RULES-1:0] count_hit;
  logic [NUM_RULES-1:0] expire;
  logic [NUM_RULES-1:0] set_next;
  logic [PORT_W-1:0] rule_port_reg [NUM_RULES];

  logic [NUM_PORTS-1:0] irq_set;
  logic [NUM_PORTS-1:0] irq_status_next;

  // Reset release

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // Time base: microsecond pulse, millisecond pulse on the same edge

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      us_cnt_reg <= '0;
      ms_cnt_reg <= '0;
      tick_us_reg <= 1'b0;
      tick_ms_reg <= 1'b0;
    end else begin
      tick_us_reg <= 1'b0;
      tick_ms_reg <= 1'b0;
      if (us_cnt_reg == US_W'(US_CYCLES - 1)) begin
        us_cnt_reg <= '0;
        tick_us_reg <= 1'b1;
        if (ms_cnt_reg == MS_W'(MS_US - 1)) begin
          ms_cnt_reg <= '0;
          tick_ms_reg <= 1'b1;
        end else begin
          ms_cnt_reg <= ms_cnt_reg + 1'b1;
        end
      end else begin
        us_cnt_reg <= us_cnt_reg + 1'b1;
      end
    end
  end

  // Per rule compare, counter and port capture

  for (genvar r = 0; r < NUM_RULES; r++) begin : g_rule
    acl_rule_compare u_cmp (
      .i_cfg(i_rule_cfg[r]),
      .i_frame(i_frame),
      .o_hit(hit[r])
    );

    assign count_rule[r] = (i_rule_cfg[r].match_layer_select == `ACL_MD_L2) &&
      (i_rule_cfg[r].compare_option_select == `ACL_L2_COUNT);
    assign count_hit[r] = i_frame_valid && count_rule[r] && hit[r];

    // Counter shares the table index with its action entry
    acl_count_unit u_cnt (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_enable(count_rule[r]),
      .i_hit(count_hit[r]),
      .i_tick_us(tick_us_reg),
      .i_tick_ms(tick_ms_reg),
      .i_action(i_action_cfg[r]),
      .o_expire(expire[r])
    );

    // Watchdog expiry has no packet, so blame the last port seen
    always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
        rule_port_reg[r] <= '0;
      end else if (count_hit[r]) begin
        rule_port_reg[r] <= i_frame_port;
      end
    end

    // Empty group never matches rather than matching everything
    assign set_next[r] = (|i_match_selection_group[r]) &&
      ((hit & i_match_selection_group[r]) == i_match_selection_group[r]);

    chk_rule_disabled: assert property (@(posedge i_clk) disable iff (!rst_n)
      i_frame_valid && i_rule_cfg[r].match_layer_select == `ACL_MD_OFF
      |=> o_match_valid && !o_match_vec[r])
      else $error("disabled rule reported a match");

    chk_l3_reserved: assert property (@(posedge i_clk) disable iff (!rst_n)
      i_frame_valid && i_rule_cfg[r].match_layer_select == `ACL_MD_L3 &&
        (i_rule_cfg[r].compare_option_select == `ACL_L3_RSV0 ||
         i_rule_cfg[r].compare_option_select == `ACL_L3_RSV3)
      |=> !o_match_vec[r])
      else $error("reserved layer 3 option matched");

    chk_set_and: assert property (@(posedge i_clk) disable iff (!rst_n)
      i_frame_valid && ((hit & i_match_selection_group[r]) != i_match_selection_group[r])
      |=> !o_set_match[r])
      else $error("group matched with a member false");

    chk_vec_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
      !i_frame_valid |=> $stable(o_match_vec[r]) && $stable(o_set_match[r]))
      else $error("result changed without a frame");
  end

  // Result vector, one frame per valid

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_match_valid <= 1'b0;
      o_match_vec <= '0;
      o_set_match <= '0;
    end else begin
      o_match_valid <= i_frame_valid;
      if (i_frame_valid) begin
        o_match_vec <= hit;
        o_set_match <= set_next;
      end
    end
  end

  // Per port interrupt status; only counters can set it

  always_comb begin
    irq_set = '0;
    for (int r = 0; r < NUM_RULES; r++) begin
      if (expire[r] && (int'(rule_port_reg[r]) < NUM_PORTS)) begin
        irq_set[rule_port_reg[r]] = 1'b1;
      end
    end
    // A set arriving with its clear survives
    irq_status_next = (o_irq_status & ~i_irq_clear) | irq_set;
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_irq_status <= '0;
      o_port_irq <= '0;
      o_irq <= 1'b0;
    end else begin
      o_irq_status <= irq_status_next;
      o_port_irq <= irq_status_next & ~i_irq_mask;
      o_irq <= |(irq_status_next & ~i_irq_mask);
    end
  end

  chk_valid_latency: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_frame_valid |=> o_match_valid && o_match_vec == $past(hit))
    else $error("frame result missing one cycle later");

  chk_irq_sticky: assert property (@(posedge i_clk) disable iff (!rst_n)
    irq_set != '0 |=> (o_irq_status & $past(irq_set)) == $past(irq_set))
    else $error("interrupt set lost");

  chk_irq_filter_quiet: assert property (@(posedge i_clk) disable iff (!rst_n)
    expire == '0 ##1 (o_irq_status & ~$past(o_irq_status)) != '0 |-> 1'b0)
    else $error("status rose without a counter event");

  chk_irq_masked: assert property (@(posedge i_clk) disable iff (!rst_n)
    ##1 o_port_irq == (o_irq_status & ~$past(i_irq_mask)) && o_irq == (|o_port_irq))
    else $error("port interrupt not gated by mask");

  chk_us_period: assert property (@(posedge i_clk) disable iff (!rst_n)
    tick_us_reg |-> ##[US_PERIOD:US_PERIOD] tick_us_reg)
    else $error("microsecond tick period wrong");

  chk_ms_align: assert property (@(posedge i_clk) disable iff (!rst_n)
    tick_ms_reg |-> tick_us_reg)
    else $error("millisecond tick off the microsecond grid");
endmodule // acl_match_engine

// ===== acl_ingress_model.sv
`timescale 1ns/1ns
module acl_ingress_model
  import acl_pkg::*;
#(
  parameter int PORT_W = 3
) (
  // Clock
  input wire logic i_clk,
  // Toward the engine
  output logic o_frame_valid,
  output acl_pkg::frame_s o_frame,
  output logic [PORT_W-1:0] o_frame_port,
  // Results back
  input wire logic i_match_valid,
  output int o_results_seen
);
  initial begin
    o_frame_valid = 1'b0;
    o_frame = '0;
    o_frame_port = '0;
    o_results_seen = 0;
  end

  always @(posedge i_clk) begin
    if (i_match_valid === 1'b1) begin
      o_results_seen++;
    end
  end

  // Idle fields show the inverse so stale values never look valid
  task automatic send(input frame_s f, input logic [PORT_W-1:0] p);
    @(posedge i_clk);
    #2;
    o_frame_valid = 1'b1;
    o_frame = f;
    o_frame_port = p;
    @(posedge i_clk);
    #2;
    o_frame_valid = 1'b0;
    o_frame = ~f;
    o_frame_port = ~p;
  endtask
endmodule // acl_ingress_model

// ===== acl_match_engine_tb.sv
`timescale 1ns/1ns
module acl_match_engine_tb;
  import acl_pkg::*;
  logic clk;
  logic rst_n;
  rule_cfg_s rules [16];
  action_cfg_s acts [16];
  logic [15:0] groups [16];
  logic [6:0] irq_mask;
  logic [6:0] irq_clear;
  logic frame_valid;
  frame_s frame;
  logic [2:0] frame_port;
  logic match_valid;
  logic [15:0] match_vec;
  logic [15:0] set_match;
  logic [6:0] irq_status;
  logic [6:0] port_irq;
  logic irq;
  int results_seen;
  int miscompares = 0;
  int total_checks = 0;

  acl_match_engine #(.US_CYCLES(2), .MS_US(4)) uut (
    .i_clk(clk), .i_rst_n(rst_n), .i_frame_valid(frame_valid), .i_frame(frame),
    .i_frame_port(frame_port), .i_rule_cfg(rules), .i_action_cfg(acts),
    .i_match_selection_group(groups), .i_irq_mask(irq_mask), .i_irq_clear(irq_clear),
    .o_match_valid(match_valid), .o_match_vec(match_vec), .o_set_match(set_match),
    .o_irq_status(irq_status), .o_port_irq(port_irq), .o_irq(irq));

  acl_ingress_model #(.PORT_W(3)) ing (
    .i_clk(clk), .o_frame_valid(frame_valid), .o_frame(frame), .o_frame_port(frame_port),
    .i_match_valid(match_valid), .o_results_seen(results_seen));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(string w, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic wait_cyc(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  function automatic logic [47:0] rv(int unsigned hi);
    return 48'($urandom_range(0, hi));
  endfunction

  function automatic rule_cfg_s rand_rule();
    rule_cfg_s c;
    c.match_layer_select = rv(3);
    c.compare_option_select = rv(3);
    c.src_sel = rv(1);
    c.match_sense = rv(1);
    c.key_addr = rv(3);
    c.ipv4_compare_ignore_bits = rv(3);
    c.key_type = rv(3);
    c.port_hi = rv(7);
    c.port_lo = rv(7);
    c.port_compare_mode = rv(3);
    c.ipv4_upper_layer_id = rv(3);
    c.tcp_control_bits_match_on = rv(1);
    c.tcp_control_bits_ignore_mask = rv(3);
    c.tcp_flag_value = rv(3);
    // Count mode is exercised on its own
    if (c.match_layer_select == 2'h1 && c.compare_option_select == 2'h0) begin
      c.compare_option_select = 2'h3;
    end
    return c;
  endfunction

  function automatic frame_s rand_frame();
    frame_s f;
    f.dst_mac = rv(3);
    f.src_mac = rv(3);
    f.ethertype = rv(3);
    f.is_ipv4 = rv(1);
    f.src_ip = rv(3);
    f.dst_ip = rv(3);
    f.ipv4_upper_layer_id = rv(3);
    f.is_tcp = f.is_ipv4 & rv(1);
    f.is_udp = f.is_ipv4 & ~f.is_tcp & rv(1);
    f.src_port = rv(7);
    f.dst_port = rv(7);
    f.tcp_seq = rv(15);
    f.tcp_flags = rv(3);
    return f;
  endfunction

  function automatic logic exp_hit(rule_cfg_s c, frame_s f);
    logic ok;
    logic cmp;
    logic [47:0] m;
    logic [31:0] a;
    logic [15:0] p;
    logic [1:0] o;
    ok = 1'b1;
    cmp = 1'b0;
    o = c.compare_option_select;
    m = c.src_sel ? f.src_mac : f.dst_mac;
    a = c.src_sel ? f.src_ip : f.dst_ip;
    p = c.src_sel ? f.src_port : f.dst_port;
    case (c.match_layer_select)
      2'h0: ok = 1'b0;
      2'h1: cmp = (!o[0] || f.ethertype == c.key_type) && (!o[1] || m == c.key_addr);
      2'h2: begin
        ok = f.is_ipv4 && (o == 2'h1 || o == 2'h2);
        if (o == 2'h1) cmp = ((a ^ c.key_addr[31:0]) & ~c.ipv4_compare_ignore_bits) == 0;
        else cmp = f.src_ip == c.key_addr[31:0] && f.dst_ip == c.ipv4_compare_ignore_bits;
      end
      default: begin
        case (o)
          2'h0: begin
            ok = f.is_ipv4;
            cmp = f.ipv4_upper_layer_id == c.ipv4_upper_layer_id;
          end
          2'h3: begin
            ok = f.is_tcp;
            cmp = f.tcp_seq == {c.port_hi, c.port_lo};
          end
          default: begin
            ok = (o == 2'h1) ? f.is_tcp : f.is_udp;
            case (c.port_compare_mode)
              2'h0: cmp = 1'b1;
              2'h1: cmp = p == c.port_hi || p == c.port_lo;
              2'h2: cmp = p >= c.port_lo && p <= c.port_hi;
              default: cmp = p < c.port_lo || p > c.port_hi;
            endcase
          end
        endcase
        // No TCP header fails the flag test, but the sense still applies
        if (c.tcp_control_bits_match_on) begin
          cmp = cmp && f.is_tcp &&
            ((f.tcp_flags ^ c.tcp_flag_value) & ~c.tcp_control_bits_ignore_mask) == 0;
        end
      end
    endcase
    return ok && (cmp == c.match_sense);
  endfunction

  function automatic logic [15:0] exp_set(logic [15:0] v);
    logic [15:0] s;
    for (int k = 0; k < 16; k++) s[k] = groups[k] != 0 && (v & groups[k]) == groups[k];
    return s;
  endfunction

  task automatic count_rule(logic ca, logic tu, logic [10:0] val);
    rules[0] = '0;
    wait_cyc(2);
    rules[0].match_layer_select = 2'h1;
    rules[0].match_sense = 1'b1;
    rules[0].key_addr = 48'h00000000000A;
    rules[0].key_type = 16'h0800;
    acts[0] = {val, tu, ca};
    wait_cyc(1);
  endtask

  task automatic clr(logic [6:0] m);
    irq_clear = m;
    wait_cyc(1);
    irq_clear = '0;
    wait_cyc(1);
  endtask

  initial begin
    #(40 * 20000);
    miscompares++;
    close_out();
  end

  initial begin
    frame_s f;
    logic [15:0] ev;
    rst_n = 1'b0;
    irq_mask = '0;
    irq_clear = '0;
    for (int r = 0; r < 16; r++) begin
      rules[r] = '0;
      acts[r] = '0;
      groups[r] = '0;
    end
    void'($urandom(32'h546016b5));
    repeat (10) @(posedge clk);
    #2;
    rst_n = 1'b1;
    wait_cyc(3);
    for (int n = 0; n < 240; n++) begin
      if (n % 12 == 0) begin
        for (int r = 0; r < 16; r++) begin
          rules[r] = rand_rule();
          groups[r] = (16'h1 << rv(15)) | (16'h1 << rv(15));
        end
        groups[15] = '0;
      end
      f = rand_frame();
      for (int r = 0; r < 16; r++) ev[r] = exp_hit(rules[r], f);
      // Valid stands one cycle only; look before the next edge
      ing.send(f, 3'(rv(6)));
      check("match_valid", 16'h1, {15'h0, match_valid});
      check("match_vec", ev, match_vec);
      check("match_vec", ev, match_vec);
      check("set_match", exp_set(ev), set_match);
    end
    wait_cyc(1);
    check("results_seen", 16'd240, 16'(results_seen));
    check("irq_status", 16'h0, {9'h0, irq_status});
    for (int r = 0; r < 16; r++) begin
      rules[r] = '0;
      groups[r] = '0;
    end
    f = '0;
    f.dst_mac = 48'h00000000000A;
    f.ethertype = 16'h0800;
    count_rule(1'b1, 1'b0, 11'h002);
    ing.send(f, 3'h3);
    wait_cyc(4);
    check("irq_status", 16'h0, {9'h0, irq_status});
    ing.send(f, 3'h3);
    wait_cyc(3);
    check("irq_status", 16'h08, {9'h0, irq_status});
    check("irq", 16'h1, {15'h0, irq});
    check("port_irq", 16'h08, {9'h0, port_irq});
    irq_mask = 7'h08;
    wait_cyc(2);
    check("port_irq", 16'h0, {9'h0, port_irq});
    check("irq", 16'h0, {15'h0, irq});
    clr(7'h08);
    irq_mask = '0;
    check("irq_status", 16'h0, {9'h0, irq_status});
    ing.send(f, 3'h3);
    wait_cyc(4);
    check("irq_status", 16'h0, {9'h0, irq_status});
    count_rule(1'b0, 1'b0, 11'h003);
    ing.send(f, 3'h5);
    wait_cyc(2);
    check("irq_status", 16'h0, {9'h0, irq_status});
    // Keep reloading faster than the count can run out
    repeat (6) ing.send(f, 3'h5);
    check("irq_status", 16'h0, {9'h0, irq_status});
    wait_cyc(14);
    check("irq_status", 16'h20, {9'h0, irq_status});
    clr(7'h20);
    count_rule(1'b0, 1'b1, 11'h003);
    ing.send(f, 3'h6);
    wait_cyc(12);
    check("irq_status", 16'h0, {9'h0, irq_status});
    wait_cyc(30);
    check("irq_status", 16'h40, {9'h0, irq_status});
    close_out();
  end
endmodule // acl_match_engine_tb
